// >>> src/cfg_pd_pkg.sv
/*
  Shared constants for the configuration status and power-down controller.
  Assumes a 10 MHz core clock.
*/
package cfg_pd_pkg;

  // Clock figures
  localparam int CLK_PERIOD_NS = 100;

  // Master-mode extra wait, least and longest, in microseconds
  localparam int MASTER_WAIT_MIN_US = 30;
  localparam int MASTER_WAIT_MAX_US = 300;
  localparam int MASTER_WAIT_MIN_CYC = (MASTER_WAIT_MIN_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int MASTER_WAIT_MAX_CYC = (MASTER_WAIT_MAX_US * 1000) / CLK_PERIOD_NS;

  // Default length of one clear cycle of the configuration memory, in cycles
  localparam int CLEAR_CYC = 16;

  // Counter width for all sequence timing
  localparam int CNT_W = 16;

  // Reset values
  localparam logic [1:0] MODE_RST = 2'h0;

  // Controller states
  typedef enum logic [2:0] {
    ST_POR,
    ST_CLEAR,
    ST_CLEAR_LAST,
    ST_WAIT,
    ST_MASTER_WAIT,
    ST_LOAD,
    ST_IN_EN,
    ST_USER
  } cfg_state_e;

endpackage

// >>> src/config_status_power_down_ctl.sv
/*
  Configuration status and power-down controller: sequences power-on clear,
  the wait state, loading, and the handover of status pins to user logic,
  and gates all user I/O during power-down.
  Assumes pins arrive asynchronous to i_clk; the loader reports progress on
  same-clock strobes; pad muxing of scan and global clock pins is modelled.
*/
// Summary of operation
// R1: Power-down disables user I/O, initialises flip-flops.
// R2: Inputs read as low during power-down.
// R3: Configuration contents kept through power-down.
// R4: Power-down suspends, then restarts, configuration.
// R5: Exit enables inputs and flip-flops before outputs.
// R6: Test data out becomes user three-state output.
// R7: Scan inputs come from pads, usable after config.
// R8: No scan macro: scan pins become user I/O.
// R9: High flag driven high until I/O active.
// R10: Low flag driven low until I/O active.
// R11: Init held low during stabilisation and clearing.
// R12: External low init holds device in wait.
// R13: Master mode waits 30 to 300 us extra.
// R14: Init low during config signals data error.
// R15: Global inputs drive global nets, else user I/O.
// R16: Program release: finish clear, one more, wait.
// R17: Mode inputs sampled after init goes high.
// R18: Done output signals configuration complete.
// R19: Power-down synchronised; outputs enable a cycle later.
// R20: Flags and init switch to user with I/O enable.
`timescale 1ns/100ps
`default_nettype none

module config_status_power_down_ctl
  import cfg_pd_pkg::*;
#(
  parameter int N_IO     = 8,
  parameter int N_GCLK   = 4,
  parameter int CLEAR_LEN = CLEAR_CYC
) (
  // Clock and reset
  input  wire logic              i_clk,
  input  wire logic              i_rst_n,
  // Control pins
  input  wire logic              i_power_down_n,
  input  wire logic              i_program_n,
  input  wire logic [1:0]        i_mode,
  input  wire logic              i_master_mode,
  // Open-drain init line
  input  wire logic              i_init_in,
  output logic                   o_init_out,
  output logic                   o_init_oe,
  // Open-drain done line
  output logic                   o_done_out,
  output logic                   o_done_oe,
  // Loader status, same clock
  input  wire logic              i_load_done,
  input  wire logic              i_load_error,
  input  wire logic              i_scan_macro_used,
  // Status flags and user pin paths
  output logic                   o_config_busy_high_flag,
  output logic                   o_config_busy_low_flag,
  input  wire logic              i_user_hdc,
  input  wire logic              i_user_ldc,
  input  wire logic              i_user_init,
  input  wire logic              i_user_init_oe,
  // Test data out pin
  input  wire logic              i_scan_tdo,
  input  wire logic              i_user_tdo,
  input  wire logic              i_user_tdo_oe,
  output logic                   o_tdo,
  output logic                   o_tdo_oe,
  // Scan input pads
  input  wire logic [2:0]        i_scan_pads,
  output logic [2:0]             o_scan_to_tap,
  output logic [2:0]             o_scan_to_logic,
  // Primary global clock inputs
  input  wire logic [N_GCLK-1:0] i_primary_global_clock_in,
  input  wire logic [N_GCLK-1:0] i_gbuf_used,
  output logic [N_GCLK-1:0]      o_global_net,
  output logic [N_GCLK-1:0]      o_gclk_user_in,
  // User I/O pads
  input  wire logic [N_IO-1:0]   i_pad_in,
  input  wire logic [N_IO-1:0]   i_core_out,
  input  wire logic [N_IO-1:0]   i_core_oe,
  output logic [N_IO-1:0]        o_core_in,
  output logic [N_IO-1:0]        o_pad_out,
  output logic [N_IO-1:0]        o_pad_oe,
  // Core control
  output logic                   o_ff_init,
  output logic                   o_config_kept,
  output logic [1:0]             o_mode
);

  ////////////////////////////////////////////////////////////////////////////

  typedef struct packed {
    logic [1:0]              pd_sync;
    logic [1:0]              prog_sync;
    logic [1:0]              init_sync;
    logic [1:0]              scan_sync0;
    logic [1:0]              scan_sync1;
    logic [1:0]              scan_sync2;
    cfg_state_e              state;
    logic [CNT_W-1:0]        cnt;
    logic                    configured;
    logic                    error;
    logic [1:0]              mode;
    logic                    in_en;
    logic                    out_en;
    logic                    ff_init;
    logic                    init_out;
    logic                    init_oe;
    logic                    done_oe;
    logic                    config_busy_high_flag;
    logic                    config_busy_low_flag;
    logic                    tdo;
    logic                    tdo_oe;
    logic [2:0]              scan_tap;
    logic [2:0]              scan_logic;
    logic [N_GCLK-1:0]       gnet;
    logic [N_GCLK-1:0]       guser;
    logic [N_IO-1:0]         core_in;
    logic [N_IO-1:0]         pad_out;
    logic [N_IO-1:0]         pad_oe;
  } ctl_s;

  ctl_s cur_ff;
  ctl_s nxt_ff;

  logic pd_act;
  logic prog_low;
  logic init_pin_high;

  // Synchronised pin levels, read only from the second stage
  assign pd_act        = ~cur_ff.pd_sync[1];
  assign prog_low      = ~cur_ff.prog_sync[1];
  assign init_pin_high = cur_ff.init_sync[1];

  // Counter reaches a target
  function automatic logic cnt_hit(input logic [CNT_W-1:0] c, input int tgt);
    cnt_hit = (c >= CNT_W'(tgt - 1));
  endfunction

  ////////////////////////////////////////////////////////////////////////////

  // Next-state logic
  always_comb begin
    nxt_ff = cur_ff;
    nxt_ff.pd_sync    = {cur_ff.pd_sync[0], i_power_down_n};     // see R19
    nxt_ff.prog_sync  = {cur_ff.prog_sync[0], i_program_n};
    nxt_ff.init_sync  = {cur_ff.init_sync[0], i_init_in};
    nxt_ff.scan_sync0 = {cur_ff.scan_sync0[0], i_scan_pads[0]};
    nxt_ff.scan_sync1 = {cur_ff.scan_sync1[0], i_scan_pads[1]};
    nxt_ff.scan_sync2 = {cur_ff.scan_sync2[0], i_scan_pads[2]};
    nxt_ff.cnt        = cur_ff.cnt + CNT_W'(1);

    // Sequencer
    case (cur_ff.state)
      ST_POR: begin
        if (cnt_hit(cur_ff.cnt, CLEAR_LEN)) begin
          nxt_ff.state = ST_CLEAR;
          nxt_ff.cnt   = '0;
        end
      end
      ST_CLEAR: begin
        if (cnt_hit(cur_ff.cnt, CLEAR_LEN) && !prog_low) begin
          nxt_ff.state = ST_CLEAR_LAST;                           // see R16
          nxt_ff.cnt   = '0;
        end else if (cnt_hit(cur_ff.cnt, CLEAR_LEN)) begin
          nxt_ff.cnt = '0;
        end
      end
      ST_CLEAR_LAST: begin
        if (cnt_hit(cur_ff.cnt, CLEAR_LEN)) begin
          nxt_ff.state = ST_WAIT;                                 // see R16
          nxt_ff.cnt   = '0;
        end
      end
      ST_WAIT: begin
        nxt_ff.cnt = '0;
        if (init_pin_high && !pd_act) begin                       // see R12
          nxt_ff.mode  = i_mode;                                  // see R17
          nxt_ff.state = i_master_mode ? ST_MASTER_WAIT : ST_LOAD;
        end
      end
      ST_MASTER_WAIT: begin
        if (!pd_act && cnt_hit(cur_ff.cnt, MASTER_WAIT_MIN_CYC)) begin
          nxt_ff.state = ST_LOAD;                                 // see R13
          nxt_ff.cnt   = '0;
        end else if (pd_act) begin
          nxt_ff.cnt = cur_ff.cnt;
        end
      end
      ST_LOAD: begin
        if (pd_act) begin
          nxt_ff.state = ST_WAIT;                                 // see R4
        end else if (i_load_error) begin
          nxt_ff.error = 1'b1;                                    // see R14
        end else if (i_load_done && !cur_ff.error) begin
          nxt_ff.configured = 1'b1;
          nxt_ff.state      = ST_IN_EN;
        end
      end
      ST_IN_EN: begin
        if (!pd_act) begin
          nxt_ff.state = ST_USER;                                 // see R5
        end
      end
      ST_USER: begin
        if (pd_act) begin
          nxt_ff.state = ST_IN_EN;                                // see R3
        end
      end
      default: begin
        nxt_ff.state = ST_POR;
      end
    endcase

    // Program low restarts clearing from any state except ST_POR and ST_CLEAR
    if (prog_low && cur_ff.state != ST_CLEAR && cur_ff.state != ST_POR) begin
      nxt_ff.state      = ST_CLEAR;
      nxt_ff.cnt        = '0;
      nxt_ff.configured = 1'b0;
      nxt_ff.error      = 1'b0;
    end

    // Input and output enables derived from the next state
    nxt_ff.in_en  = (nxt_ff.state == ST_IN_EN || nxt_ff.state == ST_USER) && !pd_act;
    nxt_ff.out_en = (nxt_ff.state == ST_USER) && cur_ff.in_en && !pd_act;  // see R5
    nxt_ff.ff_init = !nxt_ff.in_en;                               // see R1

    // Init line: low while clearing, on error, user later
    nxt_ff.init_out = 1'b0;
    if (nxt_ff.out_en) begin
      nxt_ff.init_out = i_user_init;                              // see R20
      nxt_ff.init_oe  = i_user_init_oe;
    end else begin
      nxt_ff.init_oe  = (nxt_ff.state == ST_POR) || (nxt_ff.state == ST_CLEAR) ||
                        (nxt_ff.state == ST_CLEAR_LAST) || nxt_ff.error;  // see R11
    end

    // Done is released once configuration completes
    nxt_ff.done_oe = !nxt_ff.configured;                          // see R18

    // Busy flags until I/O go active
    nxt_ff.config_busy_high_flag = nxt_ff.out_en ? i_user_hdc : 1'b1;               // see R9
    nxt_ff.config_busy_low_flag = nxt_ff.out_en ? i_user_ldc : 1'b0;               // see R10

    // Test data out
    if (nxt_ff.out_en && !i_scan_macro_used) begin
      nxt_ff.tdo    = i_user_tdo;                                 // see R6
      nxt_ff.tdo_oe = i_user_tdo_oe;
    end else begin
      nxt_ff.tdo    = i_scan_tdo;
      nxt_ff.tdo_oe = i_scan_macro_used && !pd_act;
    end

    // Scan pads: straight to the tap, to logic once configured
    nxt_ff.scan_tap   = {cur_ff.scan_sync2[1], cur_ff.scan_sync1[1], cur_ff.scan_sync0[1]};
    if (!i_scan_macro_used && cur_ff.configured) begin
      nxt_ff.scan_tap = 3'h0;                                     // see R8
    end
    nxt_ff.scan_logic = (cur_ff.configured && nxt_ff.in_en) ?
                        {cur_ff.scan_sync2[1], cur_ff.scan_sync1[1], cur_ff.scan_sync0[1]} :
                        3'h0;                                     // see R7

    // Global inputs, masked low during power-down
    for (int k = 0; k < N_GCLK; k++) begin
      nxt_ff.gnet[k]  = nxt_ff.in_en & i_gbuf_used[k] & i_primary_global_clock_in[k];
      nxt_ff.guser[k] = nxt_ff.in_en & ~i_gbuf_used[k] & i_primary_global_clock_in[k];
    end                                                           // see R15

    // User I/O gating
    nxt_ff.core_in = nxt_ff.in_en ? i_pad_in : '0;                // see R2
    nxt_ff.pad_out = nxt_ff.out_en ? i_core_out : '0;
    nxt_ff.pad_oe  = nxt_ff.out_en ? i_core_oe : '0;              // see R1
  end

  ////////////////////////////////////////////////////////////////////////////

  // State register
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      cur_ff       <= '0;
      cur_ff.state <= ST_POR;
      cur_ff.mode  <= MODE_RST;
      cur_ff.config_busy_high_flag   <= 1'b1;
      cur_ff.ff_init <= 1'b1;
      cur_ff.init_oe <= 1'b1;
      cur_ff.done_oe <= 1'b1;
      cur_ff.pd_sync <= 2'h3;
      cur_ff.prog_sync <= 2'h3;
    end else begin
      cur_ff <= nxt_ff;
    end
  end

  // Outputs straight from flip-flops, except the done output tied low
  assign o_init_out              = cur_ff.init_out;
  assign o_init_oe               = cur_ff.init_oe;
  assign o_done_out              = 1'b0;
  assign o_done_oe               = cur_ff.done_oe;
  assign o_config_busy_high_flag = cur_ff.config_busy_high_flag;
  assign o_config_busy_low_flag  = cur_ff.config_busy_low_flag;
  assign o_tdo                   = cur_ff.tdo;
  assign o_tdo_oe                = cur_ff.tdo_oe;
  assign o_scan_to_tap           = cur_ff.scan_tap;
  assign o_scan_to_logic         = cur_ff.scan_logic;
  assign o_global_net            = cur_ff.gnet;
  assign o_gclk_user_in          = cur_ff.guser;
  assign o_core_in               = cur_ff.core_in;
  assign o_pad_out               = cur_ff.pad_out;
  assign o_pad_oe                = cur_ff.pad_oe;
  assign o_ff_init               = cur_ff.ff_init;                // see R1
  assign o_config_kept           = cur_ff.configured;             // see R3
  assign o_mode                  = cur_ff.mode;

  ////////////////////////////////////////////////////////////////////////////

  // Checks
  sequence s_out_rise;
    !cur_ff.out_en ##1 cur_ff.out_en;
  endsequence

  chk_pd_io_off: assert property (@(posedge i_clk) disable iff (!i_rst_n) // see R1
    pd_act |=> (o_pad_oe == '0)) else $error("pads driven during power-down");
  chk_pd_inputs_low: assert property (@(posedge i_clk) disable iff (!i_rst_n) // see R2
    pd_act |=> (o_core_in == '0)) else $error("inputs not low in power-down");
  chk_out_after_in: assert property (@(posedge i_clk) disable iff (!i_rst_n) // see R5
    s_out_rise |-> $past(cur_ff.in_en)) else $error("outputs before inputs");
  chk_hdc_busy: assert property (@(posedge i_clk) disable iff (!i_rst_n) // see R9
    !cur_ff.out_en |-> o_config_busy_high_flag) else $error("busy high flag dropped");
  chk_ldc_busy: assert property (@(posedge i_clk) disable iff (!i_rst_n) // see R10
    !cur_ff.out_en |-> !o_config_busy_low_flag) else $error("busy low flag rose");
  chk_init_clear: assert property (@(posedge i_clk) disable iff (!i_rst_n) // see R11
    (cur_ff.state == ST_CLEAR) |-> o_init_oe) else $error("init released in clear");
  chk_wait_hold: assert property (@(posedge i_clk) disable iff (!i_rst_n) // see R12
    (cur_ff.state == ST_WAIT && !init_pin_high && !prog_low) |=> cur_ff.state == ST_WAIT)
    else $error("left wait with init low");
  chk_done_cfg: assert property (@(posedge i_clk) disable iff (!i_rst_n) // see R18
    cur_ff.configured |-> !o_done_oe) else $error("done not released");

endmodule

`default_nettype wire

// >>> tb/cfg_board_model.sv
/*
  Board-side model of the open-drain init wire with its pull-up resistor.
  Assumes the device drives the wire only while its enable is high.
*/
`timescale 1ns/100ps
`default_nettype none

module cfg_board_model (
  // Device side of the wire
  input  wire logic i_init_out,
  input  wire logic i_init_oe,
  // Board control
  input  wire logic i_hold_low,
  output logic      o_init_wire
);
  // Pull-up wins unless the device or the board pulls low
  assign o_init_wire = (i_init_oe ? i_init_out : 1'b1) & ~i_hold_low;
endmodule

`default_nettype wire

// >>> tb/tb_top.sv
/*
  Self-checking bench for the configuration status and power-down block.
  Assumes a 10 MHz clock and a clear length shortened to 4 cycles.
*/
`timescale 1ns/100ps
`default_nettype none

module tb_top;
  logic       clk, rst_n, pd_n, prog_n, master, hold, init_wire;
  logic       init_out, init_oe, done_out, done_oe, ld_done, ld_err, scan_used;
  logic       config_busy_high_flag, config_busy_low_flag, u_hdc, u_ldc, u_init, u_init_oe;
  logic       scan_tdo, u_tdo, u_tdo_oe, tdo, tdo_oe, ff_init, kept;
  logic [1:0] mode, mode_out;
  logic [2:0] pads, to_tap, to_logic;
  logic [3:0] gin, gused, gnet, guser;
  logic [7:0] pad_in, core_out, core_oe, core_in, pad_out, pad_oe;
  int         err_total, check_count, cyc;

  config_status_power_down_ctl #(.CLEAR_LEN(4)) config_status_power_down_ctl_i (
    .i_clk(clk), .i_rst_n(rst_n), .i_power_down_n(pd_n), .i_program_n(prog_n),
    .i_mode(mode), .i_master_mode(master), .i_init_in(init_wire),
    .o_init_out(init_out), .o_init_oe(init_oe), .o_done_out(done_out),
    .o_done_oe(done_oe), .i_load_done(ld_done), .i_load_error(ld_err),
    .i_scan_macro_used(scan_used), .o_config_busy_high_flag(config_busy_high_flag),
    .o_config_busy_low_flag(config_busy_low_flag), .i_user_hdc(u_hdc), .i_user_ldc(u_ldc),
    .i_user_init(u_init), .i_user_init_oe(u_init_oe), .i_scan_tdo(scan_tdo),
    .i_user_tdo(u_tdo), .i_user_tdo_oe(u_tdo_oe), .o_tdo(tdo), .o_tdo_oe(tdo_oe),
    .i_scan_pads(pads), .o_scan_to_tap(to_tap), .o_scan_to_logic(to_logic),
    .i_primary_global_clock_in(gin), .i_gbuf_used(gused), .o_global_net(gnet),
    .o_gclk_user_in(guser), .i_pad_in(pad_in), .i_core_out(core_out),
    .i_core_oe(core_oe), .o_core_in(core_in), .o_pad_out(pad_out),
    .o_pad_oe(pad_oe), .o_ff_init(ff_init), .o_config_kept(kept), .o_mode(mode_out));

  cfg_board_model cfg_board_model_i (
    .i_init_out(init_out), .i_init_oe(init_oe), .i_hold_low(hold), .o_init_wire(init_wire));

  // Free-running clock
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // Hang guard
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_total++;
      print_verdict();
    end
  end

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #10;
  endtask

  task automatic pulse(input logic is_err);
    if (is_err) ld_err = 1'b1;
    else ld_done = 1'b1;
    step(1);
    ld_err = 1'b0;
    ld_done = 1'b0;
  endtask

  task automatic prog_pulse;
    prog_n = 1'b0;
    step(3);
    prog_n = 1'b1;
  endtask

  // Device lets go of init once clearing is over
  task automatic wait_release;
    int n;
    n = 0;
    while (init_oe !== 1'b0 && n < 200) begin
      step(1);
      n++;
    end
    chk("init_release", init_oe, 1'b0);
  endtask

  // Pin handover once the I/O go active
  task automatic user_checks;
    chk("done", done_oe, 1'b0);
    chk("hdc", config_busy_high_flag, u_hdc);
    chk("ldc", config_busy_low_flag, u_ldc);
    chk("init_oe", init_oe, u_init_oe);
    chk("init_out", init_out, u_init);
    chk("done_out", done_out, 1'b0);
    chk("ff_init", ff_init, 1'b0);
    chk("pad_oe", pad_oe, core_oe);
    chk("pad_out", pad_out, core_out);
    chk("core_in", core_in, pad_in);
    chk("mode", mode_out, mode);
    chk("tdo", tdo, u_tdo);
    chk("tdo_oe", tdo_oe, u_tdo_oe);
    chk("scan_logic", to_logic, pads);
    chk("scan_tap", to_tap, 3'h0);
    chk("gnet", gnet & gused, gin & gused);
    chk("guser", guser & ~gused, gin & ~gused);
  endtask

  // Board holds init low, then releases it
  task automatic t_hold_boot;
    wait_release();
    step(20);
    pulse(1'b0);
    step(3);
    chk("held_done", done_oe, 1'b1);
    hold = 1'b0;
    step(6);
    pulse(1'b0);
    step(3);
    user_checks();
  endtask

  // Power-down in user mode, then release order
  task automatic t_pd_user;
    int ci, co;
    pd_n = 1'b0;
    step(5);
    chk("pd_oe", pad_oe, 8'h00);
    chk("pd_ff", ff_init, 1'b1);
    chk("pd_in", core_in, 8'h00);
    chk("pd_gnet", gnet, 4'h0);
    chk("pd_kept", kept, 1'b1);
    pd_n = 1'b1;
    ci = 99;
    co = 99;
    for (int i = 0; i < 10; i++) begin
      step(1);
      if (ci == 99 && core_in === pad_in) ci = i;
      if (co == 99 && pad_oe === core_oe) co = i;
    end
    chk("pd_order", co, ci + 1);
    chk("pd_noreload", done_oe, 1'b0);
  endtask

  // Data error during loading
  task automatic t_error;
    prog_pulse();
    wait_release();
    step(6);
    pulse(1'b1);
    step(3);
    chk("err_oe", init_oe, 1'b1);
    chk("err_low", init_wire, 1'b0);
    pulse(1'b0);
    step(3);
    chk("err_done", done_oe, 1'b1);
  endtask

  // Power-down in the wait state holds off loading, release lets it go on
  task automatic t_pd_config;
    prog_pulse();
    wait_release();
    pd_n = 1'b0;
    step(6);
    pulse(1'b0);
    step(3);
    chk("pdc_done", done_oe, 1'b1);
    pd_n = 1'b1;
    step(8);
    pulse(1'b0);
    step(3);
    chk("pdc_rest", done_oe, 1'b0);
  endtask

  // Master mode extra wait after init goes high
  task automatic t_master;
    master = 1'b1;
    prog_pulse();
    wait_release();
    step(250);
    pulse(1'b0);
    step(3);
    chk("mst_early", done_oe, 1'b1);
    step(80);
    pulse(1'b0);
    step(3);
    user_checks();
    // Scan macro in use: tap keeps the pads, test data out stays scan's
    scan_used = 1'b1;
    step(2);
    chk("scan_tap_used", to_tap, pads);
    chk("tdo_scan", tdo, scan_tdo);
    chk("tdo_oe_scan", tdo_oe, 1'b1);
  endtask

  task automatic print_verdict;
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // Main sequence
  initial begin
    {rst_n, prog_n, master, ld_done, ld_err, scan_used} = 6'h10;
    {pd_n, hold, u_hdc, u_ldc, u_init, u_init_oe} = 6'h36;
    {scan_tdo, u_tdo, u_tdo_oe, mode, pads} = 8'h7d;
    {gin, gused} = 8'hb5;
    {pad_in, core_out, core_oe} = 24'h5aa53c;
    {err_total, check_count, cyc} = '0;
    step(16);
    chk("rst_init", init_oe, 1'b1);
    chk("rst_hdc", config_busy_high_flag, 1'b1);
    chk("rst_ldc", config_busy_low_flag, 1'b0);
    chk("rst_oe", pad_oe, 8'h00);
    chk("rst_done", done_oe, 1'b1);
    rst_n = 1'b1;
    t_hold_boot();
    t_pd_user();
    t_error();
    t_pd_config();
    t_master();
    print_verdict();
  end
endmodule

`default_nettype wire
